// [tcs_pkg.sv]
// tcs_pkg: constants and types of the tare calibration sequencer
// Functional notes
// R1: tare input active low, open reads idle
// R2: six states idle enter bank1-3 save
// R3: four programmable timing settings; the code has five, tx period included
// R4: reset starts in idle, no calibration
// R5: enter long press: go enter, flash green
// R6: enter advances to bank one after delay
// R7: bank leds flash green, others off
// R8: engage: solid green, delay, zero, advance
// R9: banks two, three behave like bank one
// R10: save state blinks all green/red alternately
// R11: save long press commits all, idle
// R12: double press steps back one state
// R13: double press in enter cancels to idle
// R14: cancel leaves stored calibration untouched
// R15: non idle forces tx period 1000 ms
// R16: debounce tare input before timing presses
// R17: double press: two short taps, window
// R18: lone short press changes nothing
`default_nettype none
package tcs_pkg;
  // clock and millisecond tick
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  // fixed timings in ms
  localparam logic [15:0] CAL_TX_PERIOD_MS = 16'd1000;
  localparam logic [15:0] TAP_WINDOW_MS    = 16'd400;
  localparam logic [15:0] BLINK_HALF_MS    = 16'd250;
  // register byte offsets
  localparam logic [7:0] REG_DEBOUNCE  = 8'h00;
  localparam logic [7:0] REG_ENTER_LP  = 8'h04;
  localparam logic [7:0] REG_ENGAGE_LP = 8'h08;
  localparam logic [7:0] REG_EXEC_DLY  = 8'h0c;
  localparam logic [7:0] REG_TX_PERIOD = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  // reset values in ms
  localparam logic [15:0] RST_DEBOUNCE  = 16'd20;
  localparam logic [15:0] RST_ENTER_LP  = 16'd3000;
  localparam logic [15:0] RST_ENGAGE_LP = 16'd2000;
  localparam logic [15:0] RST_EXEC_DLY  = 16'd3000;
  localparam logic [15:0] RST_TX_PERIOD = 16'd100;
  // status fields and channel counts
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_SOLID_BIT = 3;
  localparam int unsigned ST_PRESS_BIT = 4;
  localparam int unsigned NUM_CH       = 12;
  localparam int unsigned BANK_CH      = 4;
  // gray coded along the forward path
  typedef enum logic [2:0] {
    CAL_IDLE  = 3'h0,
    CAL_ENTER = 3'h1,
    CAL_BANK1 = 3'h3,
    CAL_BANK2 = 3'h2,
    CAL_BANK3 = 3'h6,
    CAL_SAVE  = 3'h7
  } tcs_state_t;
endpackage : tcs_pkg
`default_nettype wire

// [tcs_sequencer.sv]
// tcs_sequencer: tare button calibration sequencer with wishbone regs
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
module tcs_sequencer #(
  parameter int unsigned TICK_CYC = tcs_pkg::CYC_PER_MS  // cycles per ms
) (
  input  wire logic        clk_i,      // 25 mhz system clock
  input  wire logic        rst_i,      // synchronous reset, high
  input  wire logic        tare_n_i,   // raw tare pin, low = pressed
  input  wire logic        wb_cyc_i,   // wishbone cycle
  input  wire logic        wb_stb_i,   // wishbone strobe
  input  wire logic        wb_we_i,    // wishbone write
  input  wire logic [7:0]  wb_adr_i,   // byte address
  input  wire logic [31:0] wb_dat_i,   // write data
  input  wire logic [3:0]  wb_sel_i,   // byte selects
  output logic             wb_ack_o,   // acknowledge
  output logic [31:0]      wb_dat_o,   // read data
  output logic [11:0]      led_grn_o,  // channel leds, green
  output logic [11:0]      led_red_o,  // channel leds, red
  output logic [2:0]       zero_bank_o,// pulse: zero bank 1..3
  output logic             save_o,     // pulse: commit all to nvm
  output logic             cal_active_o, // calibration in progress
  output logic [15:0]      tx_period_o // can tx period in ms
);
  import tcs_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

  typedef struct packed {
    logic [1:0]  sync;
    logic        dbn;
    logic        dbp;
    logic [15:0] db_cnt;
    logic [31:0] tick_cnt;
    logic [15:0] hold;
    logic        lp_done;
    logic        tap_pend;
    logic [15:0] gap;
    logic [15:0] timer;
    logic [15:0] blink_cnt;
    logic        blink;
    tcs_state_t  state;
    logic        solid;
    logic [15:0] cfg_db;
    logic [15:0] cfg_enter;
    logic [15:0] cfg_engage;
    logic [15:0] cfg_delay;
    logic [15:0] cfg_tx;
    logic        ack;
    logic [31:0] dat;
    logic [11:0] grn;
    logic [11:0] red;
    logic [2:0]  zero;
    logic        save;
    logic        active;
    logic [15:0] tx;
  } tcs_regs_t;

  tcs_regs_t s;
  tcs_regs_t next_s;

  // state after a completed step
  function automatic tcs_state_t step_fwd(input tcs_state_t st);
    case (st)
      CAL_BANK1: step_fwd = CAL_BANK2;
      CAL_BANK2: step_fwd = CAL_BANK3;
      default:   step_fwd = CAL_SAVE;
    endcase
  endfunction : step_fwd

  // state one step back
  function automatic tcs_state_t step_back(input tcs_state_t st);
    case (st)
      CAL_BANK1: step_back = CAL_ENTER;
      CAL_BANK2: step_back = CAL_BANK1;
      CAL_BANK3: step_back = CAL_BANK2;
      CAL_SAVE:  step_back = CAL_BANK3;
      default:   step_back = CAL_IDLE;
    endcase
  endfunction : step_back

  // one-hot bank index of a bank state
  function automatic logic [2:0] bank_sel(input tcs_state_t st);
    case (st)
      CAL_BANK1: bank_sel = 3'h1;
      CAL_BANK2: bank_sel = 3'h2;
      CAL_BANK3: bank_sel = 3'h4;
      default:   bank_sel = 3'h0;
    endcase
  endfunction : bank_sel

  // led mask, four channels per bank
  function automatic logic [11:0] bank_mask(input tcs_state_t st);
    logic [2:0] b;
    b = bank_sel(st);
    bank_mask = {{4{b[2]}}, {4{b[1]}}, {4{b[0]}}};
  endfunction : bank_mask

  // byte-lane merge for 16 bit settings
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0]  sel);
    wr16[7:0]  = sel[0] ? d[7:0]  : old[7:0];
    wr16[15:8] = sel[1] ? d[15:8] : old[15:8];
  endfunction : wr16

  logic        tick;
  logic        pressed_raw;
  logic        lp_evt;
  logic        dbl_evt;
  logic        wr_en;
  logic [15:0] lp_thr;
  logic        delay_done;

  always_comb begin
    next_s      = s;
    lp_evt      = 1'b0;
    dbl_evt     = 1'b0;
    next_s.zero = 3'h0;
    next_s.save = 1'b0;

    // millisecond tick; all timing settings are in ms
    tick = (s.tick_cnt == TICK_LAST);
    next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

    // two-stage synchroniser; pin idles high through pull-up
    next_s.sync = {s.sync[0], tare_n_i};
    pressed_raw = ~s.sync[1]; // R1

    // debounce: level must hold the set time before accepted
    if (pressed_raw != s.dbn) begin // R16
      if (s.db_cnt >= s.cfg_db) begin
        next_s.dbn    = pressed_raw;
        next_s.db_cnt = 16'h0;
      end else if (tick) begin
        next_s.db_cnt = s.db_cnt + 16'h1;
      end
    end else begin
      next_s.db_cnt = 16'h0;
    end
    next_s.dbp = s.dbn;

    // press duration, saturating
    if (s.dbn && !s.dbp) begin
      next_s.hold    = 16'h0;
      next_s.lp_done = 1'b0;
    end else if (s.dbn && tick && s.hold != 16'hffff) begin
      next_s.hold = s.hold + 16'h1;
    end

    // long press fires once while still held
    lp_thr = (s.state == CAL_IDLE) ? s.cfg_enter : s.cfg_engage;
    if (s.dbn && s.dbp && !s.lp_done && s.hold >= lp_thr) begin
      lp_evt         = 1'b1;
      next_s.lp_done = 1'b1;
    end

    // tap pairing on release; a long press kills a pending tap
    if (!s.dbn && s.dbp) begin
      if (s.lp_done || s.hold >= s.cfg_engage) begin
        next_s.tap_pend = 1'b0;
      end else if (s.tap_pend) begin
        dbl_evt         = 1'b1; // R17
        next_s.tap_pend = 1'b0;
      end else begin
        next_s.tap_pend = 1'b1; // R18
        next_s.gap      = 16'h0;
      end
    end else if (s.tap_pend && !s.dbn) begin
      // second press must start inside the window
      if (s.gap >= TAP_WINDOW_MS) begin
        next_s.tap_pend = 1'b0; // R17
      end else if (tick) begin
        next_s.gap = s.gap + 16'h1;
      end
    end

    // step timer
    if (tick && s.timer != 16'hffff) begin
      next_s.timer = s.timer + 16'h1;
    end
    delay_done = (s.timer >= s.cfg_delay);

    // sequencer
    case (s.state)
      CAL_IDLE: begin
        if (lp_evt) begin
          next_s.state = CAL_ENTER; // R5
        end
      end
      CAL_ENTER: begin
        if (dbl_evt) begin
          // cancel: no save pulse, nvm keeps old values
          next_s.state = CAL_IDLE; // R13 R14
        end else if (delay_done) begin
          next_s.state = CAL_BANK1; // R6
        end
      end
      CAL_BANK1, CAL_BANK2, CAL_BANK3: begin
        if (dbl_evt && (!s.solid || !delay_done)) begin
          next_s.state = step_back(s.state); // R12
          next_s.solid = 1'b0;
        end else if (s.solid && delay_done) begin
          next_s.zero  = bank_sel(s.state); // R8 R9
          next_s.state = step_fwd(s.state);
          next_s.solid = 1'b0;
        end else if (!s.solid && lp_evt) begin
          next_s.solid = 1'b1; // R8
          next_s.timer = 16'h0;
        end
      end
      CAL_SAVE: begin
        if (dbl_evt) begin
          next_s.state = CAL_BANK3; // R12
        end else if (lp_evt) begin
          next_s.save  = 1'b1; // R11
          next_s.state = CAL_IDLE;
        end
      end
      default: begin
        next_s.state = CAL_IDLE;
        next_s.solid = 1'b0;
      end
    endcase
    if (next_s.state != s.state) begin
      next_s.timer = 16'h0;
    end

    // blink phase for flashing leds
    if (s.blink_cnt >= BLINK_HALF_MS) begin
      next_s.blink_cnt = 16'h0;
      next_s.blink     = ~s.blink;
    end else if (tick) begin
      next_s.blink_cnt = s.blink_cnt + 16'h1;
    end
    // restart lit on a state change; a short state would stay dark
    if (next_s.state != s.state) begin
      next_s.blink_cnt = 16'h0;
      next_s.blink     = 1'b1;
    end

    // led feedback
    next_s.grn = 12'h000;
    next_s.red = 12'h000;
    case (s.state)
      CAL_ENTER: next_s.grn = {NUM_CH{s.blink}}; // R5
      CAL_BANK1, CAL_BANK2, CAL_BANK3: begin
        next_s.grn = bank_mask(s.state) & // R7 R9
                     {NUM_CH{s.solid | s.blink}};
      end
      CAL_SAVE: begin
        next_s.grn = {NUM_CH{s.blink}}; // R10
        next_s.red = {NUM_CH{~s.blink}};
      end
      default: next_s.grn = 12'h000;
    endcase

    // tx period override outside idle
    next_s.active = (s.state != CAL_IDLE);
    next_s.tx = next_s.active ? CAL_TX_PERIOD_MS : s.cfg_tx; // R15

    // wishbone classic slave, one wait state, ack for any address
    next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~s.ack;
    if (wr_en) begin
      case (wb_adr_i) // R3
        REG_DEBOUNCE:  next_s.cfg_db = wr16(s.cfg_db, wb_dat_i, wb_sel_i);
        REG_ENTER_LP:
          next_s.cfg_enter = wr16(s.cfg_enter, wb_dat_i, wb_sel_i);
        REG_ENGAGE_LP:
          next_s.cfg_engage = wr16(s.cfg_engage, wb_dat_i, wb_sel_i);
        REG_EXEC_DLY:
          next_s.cfg_delay = wr16(s.cfg_delay, wb_dat_i, wb_sel_i);
        REG_TX_PERIOD: next_s.cfg_tx = wr16(s.cfg_tx, wb_dat_i, wb_sel_i);
        default: next_s.cfg_tx = s.cfg_tx;
      endcase
    end
    // read data; unmapped reads zero
    case (wb_adr_i)
      REG_DEBOUNCE:  next_s.dat = {16'h0, s.cfg_db};
      REG_ENTER_LP:  next_s.dat = {16'h0, s.cfg_enter};
      REG_ENGAGE_LP: next_s.dat = {16'h0, s.cfg_engage};
      REG_EXEC_DLY:  next_s.dat = {16'h0, s.cfg_delay};
      REG_TX_PERIOD: next_s.dat = {16'h0, s.cfg_tx};
      REG_STATUS: begin
        next_s.dat = 32'h0;
        next_s.dat[ST_STATE_LSB +: 3] = s.state; // R2
        next_s.dat[ST_SOLID_BIT]      = s.solid;
        next_s.dat[ST_PRESS_BIT]      = s.dbn;
      end
      default: next_s.dat = 32'h0;
    endcase
  end

  // single state register; reset lands in idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s            <= '0; // R4
      s.sync       <= 2'h3;
      s.state      <= CAL_IDLE;
      s.cfg_db     <= RST_DEBOUNCE;
      s.cfg_enter  <= RST_ENTER_LP;
      s.cfg_engage <= RST_ENGAGE_LP;
      s.cfg_delay  <= RST_EXEC_DLY;
      s.cfg_tx     <= RST_TX_PERIOD;
      s.tx         <= RST_TX_PERIOD;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o     = s.ack;
  assign wb_dat_o     = s.dat;
  assign led_grn_o    = s.grn;
  assign led_red_o    = s.red;
  assign zero_bank_o  = s.zero;
  assign save_o       = s.save;
  assign cal_active_o = s.active;
  assign tx_period_o  = s.tx;
endmodule : tcs_sequencer
`default_nettype wire

// [tcs_button.sv]
// tcs_button: push button with contact chatter, pulled up
`default_nettype none
module tcs_button (
  input  wire logic clk_i,   // bench clock
  input  wire logic press_i, // finger down
  output logic      tare_n_o // contact, low closed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] bnc = 2'h0;
  logic       last = 1'b0;
  // chatter three cycles per change, shorter than any debounce
  always @(posedge clk_i) begin
    last <= press_i;
    bnc  <= (press_i != last) ? 2'h3 : bnc - {1'b0, bnc != 2'h0};
  end
  // open contact reads high through the pull-up
  assign tare_n_o = (bnc != 2'h0) ? bnc[0] : !press_i;
endmodule : tcs_button
`default_nettype wire

// [tcs_sequencer_asserts.sv]
// tcs_sequencer_asserts: port checks for the tare sequencer
`default_nettype none
module tcs_sequencer_asserts (
  input wire logic        clk_i,        // clock
  input wire logic        rst_i,        // reset
  input wire logic        wb_cyc_i,     // cycle
  input wire logic        wb_stb_i,     // strobe
  input wire logic        wb_ack_o,     // ack
  input wire logic [11:0] led_grn_o,    // green
  input wire logic [11:0] led_red_o,    // red
  input wire logic [2:0]  zero_bank_o,  // zero pulses
  input wire logic        save_o,       // save pulse
  input wire logic        cal_active_o, // calibrating
  input wire logic [15:0] tx_period_o   // tx period
);
  timeunit 1ns;
  timeprecision 1ns;
  import tcs_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus answer one cycle after the request, one cycle wide
  sequence s_ack1;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_zero;
    $onehot(zero_bank_o) && cal_active_o ##1 zero_bank_o == 3'h0;
  endsequence
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack1;
  endproperty
  property p_tx;
    cal_active_o |-> tx_period_o == CAL_TX_PERIOD_MS;
  endproperty
  property p_rst;
    $fell(rst_i) |-> !cal_active_o && !save_o && led_grn_o == 12'h0;
  endproperty
  property p_zero;
    zero_bank_o != 3'h0 |-> s_zero;
  endproperty
  property p_save;
    save_o |-> $past(cal_active_o) ##1 !save_o && !cal_active_o;
  endproperty
  // leds and cal_active_o both lag the state by one cycle; the past term adds a cycle of margin
  property p_red;
    led_red_o != 12'h0 |-> cal_active_o || $past(cal_active_o);
  endproperty
  property p_dark;
    !cal_active_o && !$past(cal_active_o) |-> led_grn_o == 12'h0;
  endproperty
  property p_mix;
    led_grn_o != 12'h0 |-> (led_grn_o & led_red_o) == 12'h0;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack late or long");
  a_tx: assert property (p_tx)
    else $error("tx period not forced");
  a_rst: assert property (p_rst)
    else $error("not idle after reset");
  a_zero: assert property (p_zero)
    else $error("bad zero pulse");
  a_save: assert property (p_save)
    else $error("bad save pulse");
  a_red: assert property (p_red)
    else $error("red led in idle");
  a_dark: assert property (p_dark)
    else $error("green led in idle");
  a_mix: assert property (p_mix)
    else $error("led green and red at once");
endmodule : tcs_sequencer_asserts
bind tcs_sequencer tcs_sequencer_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .led_grn_o(led_grn_o),
  .led_red_o(led_red_o), .zero_bank_o(zero_bank_o), .save_o(save_o),
  .cal_active_o(cal_active_o), .tx_period_o(tx_period_o)
);
`default_nettype wire

// [tcs_sequencer_tb.sv]
// tcs_sequencer_tb: self-checking bench for the tare sequencer
`default_nettype none
module tcs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tcs_pkg::*;
  localparam int MS = 10; // cycles per ms, short for sim
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        press = 1'b0;
  logic        tare_n;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_ack_o, save_o, cal_active_o;
  logic [31:0] wb_dat_o;
  logic [11:0] led_grn_o, led_red_o;
  logic [2:0]  zero_bank_o;
  logic [15:0] tx_period_o, txv;
  logic [31:0] rdq[$];
  logic [3:0]  evq[$];
  logic        seen_r = 1'b0;
  logic        seen_g = 1'b0;
  int          bad_count = 0;
  int          compares = 0;
  int          seed = 60312;
  int          cycles = 0;
  logic [31:0] rstv[7] = '{32'd20, 32'd3000, 32'd2000, 32'd3000,
                           32'd100, 32'h0, 32'h0};
  logic [31:0] cfg[4] = '{32'd2, 32'd20, 32'd10, 32'd30};
  always #20 clk_i = ~clk_i;
  tcs_button u_btn (.clk_i(clk_i), .press_i(press), .tare_n_o(tare_n));
  tcs_sequencer #(.TICK_CYC(MS)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .tare_n_i(tare_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .led_grn_o(led_grn_o),
    .led_red_o(led_red_o), .zero_bank_o(zero_bank_o), .save_o(save_o),
    .cal_active_o(cal_active_o), .tx_period_o(tx_period_o)
  );
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // one classic cycle; request held until ack is sampled at a rising edge
  task automatic wb(input logic w, logic [7:0] a, logic [31:0] d,
                    logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) chk("ack", 32'h1, 32'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  task automatic hold(input int on, input int off);
    press <= 1'b1;
    repeat (on * MS) @(posedge clk_i);
    press <= 1'b0;
    repeat (off * MS) @(posedge clk_i);
  endtask : hold
  task automatic dtap;
    hold(4, 4);
    hold(4, 4);
  endtask : dtap
  task automatic bank(input int b, input logic [2:0] cur, nxt);
    logic [11:0] m;
    m = 12'hf << (4 * b);
    @(negedge clk_i);
    chk("flash", 32'h0, {8'h0, led_red_o, led_grn_o & ~m});
    @(posedge clk_i);
    hold(13, 4);
    rd(REG_STATUS, {28'h0, 1'b1, cur});
    @(negedge clk_i);
    chk("solid", {20'h0, m}, {20'h0, led_grn_o});
    @(posedge clk_i);
    evq.push_back(4'(1 << b));
    repeat (30 * MS) @(posedge clk_i);
    rd(REG_STATUS, {29'h0, nxt});
    $display("test bank %0d done", b + 1);
  endtask : bank
  // read data is taken at the edge where ack is sampled high
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      chk("rdata", rdq.size() ? rdq.pop_front() : 'x, wb_dat_o);
    end
  end
  // pulse watcher: pulses are matched against the notes
  always @(negedge clk_i) begin
    if ({save_o, zero_bank_o} !== 4'h0) begin
      chk("pulse", evq.size() ? evq.pop_front() : 'x,
          {28'h0, save_o, zero_bank_o});
    end
    seen_r = seen_r | (led_red_o === 12'hfff);
    seen_g = seen_g | (led_grn_o === 12'hfff);
  end
  // a hang is cut short well past the planned length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), rstv[i]);
    end
    txv = 16'($random(seed)) | 16'h8000;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'(4 * i), cfg[i] | 32'hffff0000, 4'h3);
    end
    wb(1'b1, REG_TX_PERIOD, {16'h0, txv}, 4'h3);
    wb(1'b1, REG_TX_PERIOD, 32'h5a5, 4'h1); // low lane only
    wb(1'b1, 8'h18, 32'hffff, 4'h3);
    txv[7:0] = 8'ha5;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i), cfg[i]);
    end
    rd(REG_TX_PERIOD, {16'h0, txv});
    rd(8'h18, 32'h0);
    chk("tx idle", {16'h0, txv}, {16'h0, tx_period_o});
    $display("test registers done");
    hold(1, 4);
    hold(4, 4);
    rd(REG_STATUS, 32'h0);
    seen_g = 1'b0;
    hold(23, 4);
    rd(REG_STATUS, 32'h1);
    chk("tx cal", 32'd1000, {16'h0, tx_period_o});
    repeat (30 * MS) @(posedge clk_i);
    rd(REG_STATUS, 32'h3);
    chk("enter flash", 32'h1, {31'h0, seen_g});
    dtap();
    rd(REG_STATUS, 32'h1);
    repeat (35 * MS) @(posedge clk_i);
    rd(REG_STATUS, 32'h3);
    $display("test enter done");
    bank(0, 3'h3, 3'h2);
    bank(1, 3'h2, 3'h6);
    bank(2, 3'h6, 3'h7);
    seen_r = 1'b0;
    seen_g = 1'b0;
    repeat (520 * MS) @(posedge clk_i);
    chk("blink", 32'h3, {30'h0, seen_r, seen_g});
    dtap();
    rd(REG_STATUS, 32'h6);
    bank(2, 3'h6, 3'h7);
    evq.push_back(4'h8);
    hold(13, 4);
    rd(REG_STATUS, 32'h0);
    chk("tx back", {16'h0, txv}, {16'h0, tx_period_o});
    $display("test save done");
    hold(23, 4);
    rd(REG_STATUS, 32'h1);
    dtap();
    rd(REG_STATUS, 32'h0);
    repeat (40 * MS) @(posedge clk_i);
    $display("test cancel done");
    end_sim();
  end
endmodule : tcs_sequencer_tb
`default_nettype wire
